// *** p2mux_bit.sv ***
// Shared constants and types for the port-2 pin mux, plus the per-bit input and flag cell
`timescale 1ns/1ps
`default_nettype none

package p2mux_pkg;
	// Port width and the number of bits that reach a pad
	localparam int P2MUX_WIDTH = 8;
	localparam int P2MUX_PADS = 6;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] P2MUX_IDX_INPUT = 8'h28;
	localparam logic [7:0] P2MUX_IDX_OUTPUT = 8'h29;
	localparam logic [7:0] P2MUX_IDX_DIR = 8'h2A;
	localparam logic [7:0] P2MUX_IDX_FLAG = 8'h2B;
	localparam logic [7:0] P2MUX_IDX_EDGE = 8'h2C;
	localparam logic [7:0] P2MUX_IDX_ENABLE = 8'h2D;
	localparam logic [7:0] P2MUX_IDX_SELECT = 8'h2E;
	// Bus address width in bits and reset value of every port register
	localparam int P2MUX_ADDR_W = 10;
	localparam logic [7:0] P2MUX_REG_RESET = 8'h00;
	// Bit positions inside the port
	localparam int P2MUX_BIT_TIMER = 0;
	localparam int P2MUX_BIT_SCLK = 1;
	localparam int P2MUX_BIT_STE = 2;
	localparam int P2MUX_BIT_BUFDIS = 3;
	localparam int P2MUX_BIT_TXD = 4;
	localparam int P2MUX_BIT_RXD = 5;
	// Supervisor level that turns the bit-3 input buffer off
	localparam logic [3:0] P2MUX_LEVEL_BUF_OFF = 4'hF;
	// LCD port-select threshold from which bits 0 and 1 carry segments
	localparam int P2MUX_LCD_SEL_W = 3;
	localparam logic [2:0] P2MUX_LCD_THRESHOLD = 3'h4;
	// Edge-select encoding
	localparam logic P2MUX_EDGE_RISE = 1'b0;

	// Drive of the six bonded pads
	typedef struct packed {
		logic [5:0] out;
		logic [5:0] oe;
	} p2mux_pad_t;
endpackage

module p2mux_bit #(
	parameter bit HAS_PAD = 1'b1
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_pad,
	input wire logic i_edge_sel,
	input wire logic i_flag_wr,
	input wire logic i_flag_wdata,
	output logic o_level,
	output logic o_flag
);
	import p2mux_pkg::*;

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;
	logic flag_reg;
	logic edge_hit;

	// Two-flop synchroniser, left running through reset so the edge compare
	// starts from the real pin level; unbonded bits hold a constant low level
	always_ff @(posedge i_clk_sys) begin
		if (!HAS_PAD) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= i_pad;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// R11 selected edge detect
	assign edge_hit = HAS_PAD && ((i_edge_sel == P2MUX_EDGE_RISE) ?
		(sync_reg && !prev_reg) : (!sync_reg && prev_reg));

	// R7 R11 flag update; a hardware edge wins over a software clear
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			flag_reg <= 1'b0;
		end else if (edge_hit) begin
			flag_reg <= 1'b1;
		end else if (i_flag_wr) begin
			flag_reg <= i_flag_wdata;
		end
	end

	assign o_level = sync_reg;
	assign o_flag = flag_reg;
endmodule

`default_nettype wire

// *** p2mux_top.sv ***
// Port-2 pin function mux with its register file on an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - Bit 0 carries timer channel-2 compare and capture
// R2 - Bit 1 serial clock, direction from module
// R3 - Bit 2 forced input, slave enable, out low
// R4 - Bit 3 port direction, buffer off at 1111b
// R5 - Bit 4 forced output driving serial transmit
// R6 - Bit 5 forced input, serial receive, out low
// R7 - Bits 6,7 unbonded, flags set by software
// R8 - Bits 0,1 become segments S25,S24 at 04h+
// R9 - Each bit has enable, flag, edge select
// R10 - Plain I/O drives output bit, reads pin
// R11 - Flag on chosen edge, request when enabled
module p2mux_top (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Avalon-MM slave
	input wire logic [p2mux_pkg::P2MUX_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Pads of the six bonded bits
	input wire logic [p2mux_pkg::P2MUX_PADS-1:0] i_pad_in,
	output p2mux_pkg::p2mux_pad_t o_pad,
	// Fields owned by other modules, same clock
	input wire logic [3:0] i_supervisor_level_field,
	input wire logic [p2mux_pkg::P2MUX_LCD_SEL_W-1:0] i_lcd_port_select_field,
	input wire logic i_lcd_segment_s25,
	input wire logic i_lcd_segment_s24,
	// Timer channel 2
	input wire logic i_timer_ch2_compare_out,
	output logic o_timer_ch2_capture_in_a,
	// Serial module
	input wire logic i_serial_clock_line,
	input wire logic i_serial_clock_dir_from_module,
	output logic o_serial_clock_line,
	output logic o_slave_transmit_enable_in,
	input wire logic i_serial_transmit_line,
	output logic o_serial_receive_line,
	// Port interrupt request
	output logic o_port_irq
);
	import p2mux_pkg::*;

	logic [7:0] port_function_select_reg;
	logic [7:0] port_direction_reg;
	logic [7:0] port_output_value_reg;
	logic [7:0] port_irq_enable_reg;
	logic [7:0] port_irq_edge_select_reg;
	logic [7:0] port_irq_flag;
	logic [7:0] port_input_value;
	logic [P2MUX_WIDTH-1:0] pad_level;
	logic [P2MUX_PADS-1:0] pad_gated;
	logic input_buffer_disable;
	logic lcd_mode;
	logic ack_reg;
	logic [31:0] readdata_reg;
	logic req;
	logic [7:0] idx;
	logic aligned;
	logic wr_lane0;
	logic [7:0] rd_value;
	logic flag_wr;
	p2mux_pad_t pad_next;

	// Request decode; low address bits must be zero for a hit
	assign req = i_avs_read || i_avs_write;
	assign idx = i_avs_address[P2MUX_ADDR_W-1:2];
	assign aligned = (i_avs_address[1:0] == 2'b00);
	assign wr_lane0 = i_avs_write && ack_reg && aligned && i_avs_byteenable[0];

	// One wait cycle per access: request seen, then answered
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req && !ack_reg;
		end
	end
	assign o_avs_waitrequest = req && !ack_reg;

	// Read mux; unmapped or misaligned addresses read zero
	always_comb begin
		rd_value = 8'h00;
		if (aligned) begin
			case (idx)
				P2MUX_IDX_INPUT: rd_value = port_input_value;
				P2MUX_IDX_OUTPUT: rd_value = port_output_value_reg;
				P2MUX_IDX_DIR: rd_value = port_direction_reg;
				P2MUX_IDX_FLAG: rd_value = port_irq_flag;
				P2MUX_IDX_EDGE: rd_value = port_irq_edge_select_reg;
				P2MUX_IDX_ENABLE: rd_value = port_irq_enable_reg;
				P2MUX_IDX_SELECT: rd_value = port_function_select_reg;
				default: rd_value = 8'h00;
			endcase
		end
	end

	// Read data captured in the wait cycle, stands at the answering edge
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			readdata_reg <= 32'h0000_0000;
		end else if (i_avs_read && !ack_reg) begin
			readdata_reg <= {24'h00_0000, rd_value};
		end
	end
	assign o_avs_readdata = readdata_reg;

	// R10 software-written control registers; writes land on the answering edge
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			port_output_value_reg <= P2MUX_REG_RESET;
			port_direction_reg <= P2MUX_REG_RESET;
			port_function_select_reg <= P2MUX_REG_RESET;
		end else if (wr_lane0) begin
			case (idx)
				P2MUX_IDX_OUTPUT: port_output_value_reg <= i_avs_writedata[7:0];
				P2MUX_IDX_DIR: port_direction_reg <= i_avs_writedata[7:0];
				P2MUX_IDX_SELECT: port_function_select_reg <= i_avs_writedata[7:0];
				default: port_output_value_reg <= port_output_value_reg;
			endcase
		end
	end

	// R9 interrupt enable and edge select for all eight bits
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			port_irq_enable_reg <= P2MUX_REG_RESET;
			port_irq_edge_select_reg <= P2MUX_REG_RESET;
		end else if (wr_lane0) begin
			case (idx)
				P2MUX_IDX_ENABLE: port_irq_enable_reg <= i_avs_writedata[7:0];
				P2MUX_IDX_EDGE: port_irq_edge_select_reg <= i_avs_writedata[7:0];
				default: port_irq_enable_reg <= port_irq_enable_reg;
			endcase
		end
	end

	assign flag_wr = wr_lane0 && (idx == P2MUX_IDX_FLAG);

	// R4 bit-3 buffer off; gating ahead of the synchroniser keeps its input quiet
	assign input_buffer_disable = (i_supervisor_level_field == P2MUX_LEVEL_BUF_OFF);
	always_comb begin
		pad_gated = i_pad_in;
		pad_gated[P2MUX_BIT_BUFDIS] = i_pad_in[P2MUX_BIT_BUFDIS] && !input_buffer_disable;
	end

	// R9 R11 one synchroniser and flag cell per bit
	genvar g;
	generate
		for (g = 0; g < P2MUX_WIDTH; g++) begin : gen_bit
			if (g < P2MUX_PADS) begin : gen_pad
				p2mux_bit #(
					.HAS_PAD(1'b1)
				) u_bit (
					.i_clk_sys(i_clk_sys),
					.i_rst(i_rst),
					.i_pad(pad_gated[g]),
					.i_edge_sel(port_irq_edge_select_reg[g]),
					.i_flag_wr(flag_wr),
					.i_flag_wdata(i_avs_writedata[g]),
					.o_level(pad_level[g]),
					.o_flag(port_irq_flag[g])
				);
			end else begin : gen_nopad
				// R7 unbonded bit, flag moves only by software
				p2mux_bit #(
					.HAS_PAD(1'b0)
				) u_bit (
					.i_clk_sys(i_clk_sys),
					.i_rst(i_rst),
					.i_pad(1'b0),
					.i_edge_sel(port_irq_edge_select_reg[g]),
					.i_flag_wr(flag_wr),
					.i_flag_wdata(i_avs_writedata[g]),
					.o_level(pad_level[g]),
					.o_flag(port_irq_flag[g])
				);
			end
		end
	endgenerate

	// R10 input register shows the synchronised pin levels
	assign port_input_value = pad_level;

	// R11 request while any flag meets its enable
	assign o_port_irq = |(port_irq_flag & port_irq_enable_reg);

	// Peripheral inputs, low when the bit is plain I/O
	always_comb begin
		// R1 capture input A
		o_timer_ch2_capture_in_a = port_function_select_reg[P2MUX_BIT_TIMER]
			&& pad_level[P2MUX_BIT_TIMER];
		// R2 serial clock inbound
		o_serial_clock_line = port_function_select_reg[P2MUX_BIT_SCLK]
			&& pad_level[P2MUX_BIT_SCLK];
		// R3 slave transmit enable
		o_slave_transmit_enable_in = port_function_select_reg[P2MUX_BIT_STE]
			&& pad_level[P2MUX_BIT_STE];
		// R6 receive data
		o_serial_receive_line = port_function_select_reg[P2MUX_BIT_RXD]
			&& pad_level[P2MUX_BIT_RXD];
	end

	// R8 segment mode takes bits 0 and 1 from the port
	assign lcd_mode = (i_lcd_port_select_field >= P2MUX_LCD_THRESHOLD);

	// Pad drive per bit; plain I/O is the fallback everywhere
	always_comb begin
		// R10 plain I/O default
		pad_next.out = port_output_value_reg[P2MUX_PADS-1:0];
		pad_next.oe = port_direction_reg[P2MUX_PADS-1:0];
		// R1 compare output, direction still from port
		if (port_function_select_reg[P2MUX_BIT_TIMER]) begin
			pad_next.out[P2MUX_BIT_TIMER] = i_timer_ch2_compare_out;
		end
		// R2 serial module owns the clock pin direction
		if (port_function_select_reg[P2MUX_BIT_SCLK]) begin
			pad_next.out[P2MUX_BIT_SCLK] = i_serial_clock_line;
			pad_next.oe[P2MUX_BIT_SCLK] = i_serial_clock_dir_from_module;
		end
		// R3 forced input, output tied low
		if (port_function_select_reg[P2MUX_BIT_STE]) begin
			pad_next.out[P2MUX_BIT_STE] = 1'b0;
			pad_next.oe[P2MUX_BIT_STE] = 1'b0;
		end
		// R4 no peripheral drive, direction from port
		if (port_function_select_reg[P2MUX_BIT_BUFDIS]) begin
			pad_next.out[P2MUX_BIT_BUFDIS] = 1'b0;
		end
		// R5 forced output carrying transmit data
		if (port_function_select_reg[P2MUX_BIT_TXD]) begin
			pad_next.out[P2MUX_BIT_TXD] = i_serial_transmit_line;
			pad_next.oe[P2MUX_BIT_TXD] = 1'b1;
		end
		// R6 forced input, output tied low
		if (port_function_select_reg[P2MUX_BIT_RXD]) begin
			pad_next.out[P2MUX_BIT_RXD] = 1'b0;
			pad_next.oe[P2MUX_BIT_RXD] = 1'b0;
		end
		// R8 segment drive overrides everything on bits 0 and 1
		if (lcd_mode) begin
			pad_next.out[P2MUX_BIT_TIMER] = i_lcd_segment_s25;
			pad_next.oe[P2MUX_BIT_TIMER] = 1'b1;
			pad_next.out[P2MUX_BIT_SCLK] = i_lcd_segment_s24;
			pad_next.oe[P2MUX_BIT_SCLK] = 1'b1;
		end
	end
	// Combinational so peripheral timing is not delayed by a cycle
	assign o_pad = pad_next;
endmodule

`default_nettype wire

// *** p2mux_chk.sv ***
// Port-level assertions for the port-2 pin mux
`timescale 1ns/1ps
`default_nettype none
module p2mux_chk (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [p2mux_pkg::P2MUX_PADS-1:0] i_pad_in,
	input wire logic [3:0] i_supervisor_level_field,
	input wire p2mux_pkg::p2mux_pad_t o_pad,
	input wire logic [p2mux_pkg::P2MUX_LCD_SEL_W-1:0] i_lcd_port_select_field,
	input wire logic i_lcd_segment_s25,
	input wire logic i_lcd_segment_s24,
	input wire logic o_timer_ch2_capture_in_a,
	input wire logic o_serial_clock_line,
	input wire logic o_slave_transmit_enable_in,
	input wire logic o_serial_receive_line,
	input wire logic o_port_irq
);
	import p2mux_pkg::*;
	logic [3:0] pchg_reg;
	// Pad or buffer-gate change history; a flag may follow a change by three edges
	always_ff @(posedge i_clk_sys) begin
		pchg_reg <= {pchg_reg[2:0], (|(i_pad_in ^ $past(i_pad_in)))
			|| (i_supervisor_level_field != $past(i_supervisor_level_field))};
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	sequence s_one_wait;
		o_avs_waitrequest ##1 !o_avs_waitrequest;
	endsequence
	// Bus handshake: one wait cycle, none while idle
	AST_WAIT_ONE: assert property ($rose(i_avs_read | i_avs_write) |-> s_one_wait)
		else $error("waitrequest not exactly one cycle");
	AST_IDLE_NOWAIT: assert property (!(i_avs_read | i_avs_write) |-> !o_avs_waitrequest)
		else $error("waitrequest while idle");
	AST_RD_UPPER: assert property (o_avs_readdata[31:8] == 24'h00_0000)
		else $error("readdata upper bits set");
	// Segment mode overrides bits 0 and 1
	AST_LCD_SEG: assert property ((i_lcd_port_select_field >= P2MUX_LCD_THRESHOLD) |->
		o_pad.oe[1:0] == 2'h3 && o_pad.out[1:0] == {i_lcd_segment_s24, i_lcd_segment_s25})
		else $error("segment drive wrong");
	// Peripheral inputs come only from a pad that was high two edges back
	AST_CAPT_SYNC: assert property (o_timer_ch2_capture_in_a |-> $past(i_pad_in[0], 2))
		else $error("capture input without pad");
	AST_SCLK_SYNC: assert property (o_serial_clock_line |-> $past(i_pad_in[1], 2))
		else $error("serial clock without pad");
	AST_STE_SYNC: assert property (o_slave_transmit_enable_in |-> $past(i_pad_in[2], 2))
		else $error("slave enable without pad");
	AST_RXD_SYNC: assert property (o_serial_receive_line |-> $past(i_pad_in[5], 2))
		else $error("receive line without pad");
	// Request moves only after a write or a recent pad or buffer-gate change
	AST_IRQ_CAUSE: assert property ($changed(o_port_irq) |-> $past(i_avs_write) || |pchg_reg)
		else $error("irq changed without cause");
endmodule
bind p2mux_top p2mux_chk p2mux_chk_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_pad_in(i_pad_in), .o_pad(o_pad),
	.i_supervisor_level_field(i_supervisor_level_field),
	.i_lcd_port_select_field(i_lcd_port_select_field), .i_lcd_segment_s25(i_lcd_segment_s25),
	.i_lcd_segment_s24(i_lcd_segment_s24), .o_timer_ch2_capture_in_a(o_timer_ch2_capture_in_a),
	.o_serial_clock_line(o_serial_clock_line), .o_serial_receive_line(o_serial_receive_line),
	.o_slave_transmit_enable_in(o_slave_transmit_enable_in), .o_port_irq(o_port_irq));
`default_nettype wire

// *** p2mux_pads.sv ***
// Pad model: outside source unless the mux drives the pin
`timescale 1ns/1ps
`default_nettype none
module p2mux_pads (
	input wire p2mux_pkg::p2mux_pad_t i_pad,
	input wire logic [5:0] i_ext,
	output logic [5:0] o_pin
);
	import p2mux_pkg::*;
	// Mux drive wins over the weak outside source
	assign o_pin = (i_pad.oe & i_pad.out) | (~i_pad.oe & i_ext);
endmodule
`default_nettype wire

// *** p2mux_top_bench.sv ***
// Self-checking bench for the port-2 pin mux
`timescale 1ns/1ps
`default_nettype none
module p2mux_top_bench;
	import p2mux_pkg::*;
	logic clk, rst, rd, wr, cmp, sck_i, sck_dir, txd, s25, s24;
	logic wreq, capt, sck_o, ste, rxd, irq;
	logic [9:0] adr;
	logic [31:0] wd, rdat;
	logic [3:0] be, lvl;
	logic [2:0] lcd;
	logic [5:0] ext, pin;
	p2mux_pad_t pad;
	int n_errors = 0;
	int total_checks = 0;
	p2mux_top p2mux_top_i (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_pad_in(pin), .o_pad(pad),
		.i_supervisor_level_field(lvl), .i_lcd_port_select_field(lcd),
		.i_lcd_segment_s25(s25), .i_lcd_segment_s24(s24), .i_timer_ch2_compare_out(cmp),
		.o_timer_ch2_capture_in_a(capt), .i_serial_clock_line(sck_i),
		.i_serial_clock_dir_from_module(sck_dir), .o_serial_clock_line(sck_o),
		.o_slave_transmit_enable_in(ste), .i_serial_transmit_line(txd),
		.o_serial_receive_line(rxd), .o_port_irq(irq));
	p2mux_pads p2mux_pads_i (.i_pad(pad), .i_ext(ext), .o_pin(pin));
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One bus cycle; held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
		output logic [7:0] q);
		rd <= !w;
		wr <= w;
		adr <= {i, 2'h0};
		wd <= {24'h00_0000, d};
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, i, d, q);
	endtask
	task automatic creg(input logic [7:0] i, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, i, 8'h00, q);
		chk({24'h00_0000, q}, {24'h00_0000, e});
	endtask
	// Segment mode overrides bits 0 and 1
	function automatic logic [11:0] exp_pad(input logic [5:0] oe, input logic [5:0] out);
		exp_pad = {out, oe};
		if (lcd >= 3'h4) begin
			exp_pad[7:6] = {s24, s25};
			exp_pad[1:0] = 2'h3;
		end
	endfunction
	// Bit 3 reads low while its buffer is off
	function automatic logic [7:0] exp_in(input logic [5:0] p);
		exp_in = {2'h0, p};
		if (lvl == 4'hF) exp_in[3] = 1'b0;
	endfunction
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (8000) @(posedge clk);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		logic [7:0] d, o, e, fl;
		logic [5:0] eo, ev, p, old;
		logic [11:0] ep;
		void'($urandom(32'h355c_c3d6));
		{rd, wr, cmp, sck_i, sck_dir, txd, s25, s24, adr, wd, lvl, lcd, ext} = '0;
		be = 4'h1;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 8'h28; i <= 8'h2E; i++) creg(8'(i), 8'h00);
		// Read back, then refused writes
		for (int i = 8'h29; i <= 8'h2E; i++) begin
			d = 8'($urandom);
			if (i != 8'h2B) wreg(8'(i), d);
			if (i != 8'h2B) creg(8'(i), d);
		end
		be <= 4'h0;
		wreg(8'h2E, ~d);
		be <= 4'h1;
		creg(8'h2E, d);
		wreg(8'h30, 8'hFF);
		creg(8'h30, 8'h00);
		// Plain I/O and peripheral modes alternate with random inputs
		for (int k = 0; k < 24; k++) begin
			{d, o} = 16'($urandom);
			{cmp, sck_i, sck_dir, txd, s25, s24, lcd} <= 9'($urandom);
			ext <= 6'($urandom);
			lvl <= (k % 3 == 0) ? 4'hF : 4'($urandom_range(0, 14));
			wreg(8'h2A, d);
			wreg(8'h29, o);
			wreg(8'h2E, (k % 2) ? 8'h3F : 8'h00);
			repeat (3) @(posedge clk);
			eo = (k % 2) ? {2'b01, d[3], 1'b0, sck_dir, d[0]} : d[5:0];
			ev = (k % 2) ? {1'b0, txd, 2'b00, sck_i, cmp} : o[5:0];
			ep = exp_pad(eo, ev);
			p = (ep[5:0] & ep[11:6]) | (~ep[5:0] & ext);
			chk(pad, ep);
			creg(8'h28, exp_in(p));
			chk({capt, sck_o, ste, rxd}, (k % 2) ? {p[0], p[1], p[2], p[5]} : 4'h0);
		end
		// Edge flags on the chosen transition
		wreg(8'h2E, 8'h00);
		wreg(8'h2A, 8'h00);
		lcd <= 3'h0;
		lvl <= 4'h0;
		wreg(8'h2D, 8'hFF);
		for (int k = 0; k < 6; k++) begin
			e = 8'($urandom);
			wreg(8'h2C, e);
			wreg(8'h2B, 8'h00);
			old = ext;
			ev = 6'($urandom);
			ext <= ev;
			repeat (4) @(posedge clk);
			fl = {2'b00, (e[5:0] & old & ~ev) | (~e[5:0] & ~old & ev)};
			creg(8'h2B, fl);
			chk(irq, |fl);
		end
		// Unbonded bits are software flags only
		wreg(8'h2B, 8'hC0);
		creg(8'h2B, 8'hC0);
		chk(irq, 1'b1);
		wreg(8'h2D, 8'h3F);
		chk(irq, 1'b0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
